/* logic/mbs_pkg.sv */
// Constants, register numbers and helpers for the RTU slave map.
// Assumes one 125 MHz system clock and a byte-wide UART on both sides.
package mbs_pkg;
	// ----------------------------------------------------------------
	// Character timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int BAUD = 19200;
	localparam int CHAR_BITS = 11;
	localparam int CHAR_CLKS = CLK_HZ * CHAR_BITS / BAUD;
	// Gaps of 1.5 and 3.5 characters, rounded up
	localparam int GAP15_CLKS = (3 * CHAR_CLKS + 1) / 2;
	localparam int GAP35_CLKS = (7 * CHAR_CLKS + 1) / 2;

	// ----------------------------------------------------------------
	// Frame fields and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_BCAST = 8'h00;
	localparam logic [7:0] ADDR_MAX = 8'hf7;
	localparam logic [7:0] FN_RD_COILS = 8'h01;
	localparam logic [7:0] FN_RD_REGS = 8'h03;
	localparam logic [7:0] FN_WR_COIL = 8'h05;
	localparam logic [7:0] FN_WR_REG = 8'h06;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_NO_WRITE = 8'h0b;
	localparam logic [7:0] EXC_BAD_ADDR = 8'h40;
	localparam logic [7:0] EXC_BAD_LEN = 8'h41;
	localparam logic [7:0] EXC_BAD_VALUE = 8'h42;
	localparam logic [7:0] EXC_BAD_FUNC = 8'h43;
	localparam logic [7:0] EXC_NONE = 8'hff;
	localparam logic [7:0] REG_BYTES = 8'h02;
	localparam logic [3:0] REQ_LEN = 4'h8;
	localparam logic [3:0] FRAME_MIN = 4'h4;
	localparam logic [3:0] EXC_LEN = 4'h3;
	localparam logic [3:0] RDREG_LEN = 4'h5;
	localparam logic [3:0] ECHO_LEN = 4'h6;
	localparam int REP_MAX = 12;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [15:0] CRC_GOOD = 16'h0000;

	// ----------------------------------------------------------------
	// Coil map (zero-based addresses)
	// ----------------------------------------------------------------
	localparam logic [15:0] COIL_REF = 16'h0010;
	localparam logic [15:0] COIL_STATE = 16'h0020;
	localparam logic [15:0] COIL_STORE = 16'h0040;
	localparam logic [15:0] COIL_COUNT = 16'h0041;
	localparam logic [15:0] COIL_ON = 16'hff00;
	localparam logic [15:0] COIL_OFF = 16'h0000;
	localparam logic [15:0] QTY_ONE = 16'h0001;

	// ----------------------------------------------------------------
	// Holding register numbers (frame address plus one)
	// ----------------------------------------------------------------
	localparam logic [19:0] REG_LAST_ERR = 20'h00007;
	localparam logic [19:0] REG_INDEX = 20'h00009;
	localparam logic [19:0] REG_REF = 20'h0c35a;
	localparam logic [19:0] REG_STATE = 20'h0c418;
	localparam logic [19:0] REG_ACT = 20'h0c422;
	localparam logic [19:0] REG_CMD = 20'h7a120;
	localparam logic [19:0] PAR_LO = 20'h00064;
	localparam logic [19:0] PAR_HI = 20'h0c34f;
	localparam logic [19:0] REGS_PER_PAR = 20'h0000a;
	localparam logic [15:0] RST_WORD = 16'h0000;

	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 32;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EXEC = 3'b001,
		ST_WAIT = 3'b011,
		ST_SEND = 3'b010,
		ST_CRCL = 3'b110,
		ST_CRCH = 3'b111
	} mbs_state_t;

	// One byte of the reflected CRC, least significant bit first
	function automatic logic [15:0] mbs_crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction : mbs_crc_step
endpackage : mbs_pkg

/* logic/mbs_rtu_slave.sv */
// RTU slave frame handling, coil and holding-register map, reply FIFO.
// Assumes byte-level UART receive and transmit on the same clock and a
// drive-side parameter store that answers each request with par_ack.
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Reply byte FIFO with a registered output stage
// ----------------------------------------------------------------
module mbs_fifo
	import mbs_pkg::*;
#(
	parameter int WIDTH = FIFO_WIDTH,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] fill;
	wire push = in_valid && in_ready;
	wire load = (fill != '0) && (!out_valid || out_ready);
	assign in_ready = fill != (AW + 1)'(DEPTH);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (load) begin
				out_data <= mem[rd_ptr];
				rd_ptr <= rd_ptr + 1'b1;
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
			fill <= fill + (AW + 1)'(push) - (AW + 1)'(load);
		end
	end
endmodule : mbs_fifo

// ----------------------------------------------------------------
// Slave top
// ----------------------------------------------------------------
module mbs_rtu_slave
	import mbs_pkg::*;
#(
	parameter int GAP_FLUSH_CLKS = GAP15_CLKS,
	parameter int GAP_END_CLKS = GAP35_CLKS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] station_addr,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	input wire logic [15:0] drive_state_word,
	input wire logic [15:0] main_actual_value,
	output logic [15:0] drive_command_word,
	output logic [15:0] bus_speed_reference,
	output logic store_to_nv,
	output logic [15:0] parameter_array_index,
	output logic par_req,
	output logic par_we,
	output logic [15:0] par_num,
	output logic [15:0] par_wdata,
	input wire logic par_ack,
	input wire logic [15:0] par_rdata,
	input wire logic par_err,
	input wire logic [7:0] par_err_code
);
	mbs_state_t st;
	mbs_state_t next_st;
	logic [7:0] req [0:7];
	logic [3:0] rx_cnt;
	logic [3:0] frame_len;
	logic [15:0] crc_rx;
	logic [31:0] gap;
	logic closed;
	logic [7:0] rep [0:REP_MAX-1];
	logic [3:0] rep_len;
	logic [3:0] idx;
	logic [15:0] crc_tx;
	logic [15:0] last_error_code;

	// ----------------------------------------------------------------
	// Frame boundaries by bus silence
	// ----------------------------------------------------------------
	wire flush = rx_valid && closed;
	wire frame_end = (gap == 32'(GAP_END_CLKS)) && rx_cnt != 4'h0 && st == ST_IDLE;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			gap <= 32'h0000_0000;
		end else if (rx_valid) begin
			gap <= 32'h0000_0000;
		end else if (gap != 32'(GAP_END_CLKS)) begin
			gap <= gap + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			closed <= 1'b1;
		end else if (rx_valid) begin
			closed <= 1'b0;
		end else if (gap == 32'(GAP_FLUSH_CLKS)) begin
			closed <= 1'b1;
		end
	end

	// Check value runs over all bytes, its own included; a good frame leaves zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_cnt <= 4'h0;
			crc_rx <= CRC_INIT;
		end else if (flush) begin
			rx_cnt <= 4'h1;
			crc_rx <= mbs_crc_step(CRC_INIT, rx_data);
		end else if (rx_valid) begin
			rx_cnt <= (rx_cnt == 4'hf) ? rx_cnt : rx_cnt + 4'h1;
			crc_rx <= mbs_crc_step(crc_rx, rx_data);
		end else if (frame_end) begin
			rx_cnt <= 4'h0;
		end
	end

	// Length is latched because the byte counter clears as the frame closes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_len <= 4'h0;
		end else if (frame_end) begin
			frame_len <= rx_cnt;
		end
	end

	always_ff @(posedge clk) begin
		if (flush) begin
			req[0] <= rx_data;
		end else if (rx_valid && rx_cnt < REQ_LEN) begin
			req[rx_cnt[2:0]] <= rx_data;
		end
	end

	// ----------------------------------------------------------------
	// Request decode
	// ----------------------------------------------------------------
	wire [7:0] fn = req[1];
	wire [15:0] start = {req[2], req[3]};
	wire [15:0] value = {req[4], req[5]};
	wire [19:0] reg_no = {4'h0, start} + 20'h00001;
	wire crc_ok = crc_rx == CRC_GOOD;
	wire bcast = req[0] == ADDR_BCAST;
	wire own_ok = station_addr != ADDR_BCAST && station_addr <= ADDR_MAX;
	wire for_us = bcast || (own_ok && req[0] == station_addr);
	wire take = frame_end && crc_ok && rx_cnt >= FRAME_MIN && for_us;

	wire bad_fn = fn != FN_RD_COILS && fn != FN_RD_REGS && fn != FN_WR_COIL && fn != FN_WR_REG;
	wire [16:0] coil_end = {1'b0, start} + {1'b0, value};
	wire coil_rng = coil_end <= {1'b0, COIL_COUNT};
	wire coil_wr_ok = start < COIL_STATE || start == COIL_STORE;
	wire is_par = reg_no >= PAR_LO && reg_no <= PAR_HI;
	wire wr_hit = reg_no == REG_INDEX || reg_no == REG_REF || reg_no == REG_CMD;
	wire rd_hit = wr_hit || reg_no == REG_LAST_ERR || reg_no == REG_STATE || reg_no == REG_ACT;

	// Registers 1-6 and 8 fall through to the address exception
	wire [15:0] rd_word = reg_no == REG_LAST_ERR ? last_error_code :
		reg_no == REG_INDEX ? parameter_array_index :
		reg_no == REG_REF ? bus_speed_reference :
		reg_no == REG_STATE ? drive_state_word :
		reg_no == REG_ACT ? main_actual_value : drive_command_word;

	wire [7:0] rd_coil_exc = value == COIL_OFF ? EXC_BAD_VALUE :
		coil_rng ? EXC_NONE : EXC_BAD_ADDR;
	// Registers are read one at a time; a parameter answer is a single word
	wire [7:0] rd_reg_exc = value != QTY_ONE ? EXC_BAD_VALUE :
		(is_par || rd_hit) ? EXC_NONE : EXC_BAD_ADDR;
	wire [7:0] wr_coil_exc = (value != COIL_ON && value != COIL_OFF) ? EXC_BAD_VALUE :
		coil_wr_ok ? EXC_NONE : start < COIL_COUNT ? EXC_NO_WRITE : EXC_BAD_ADDR;
	wire [7:0] wr_reg_exc = (is_par || wr_hit) ? EXC_NONE :
		rd_hit ? EXC_NO_WRITE : EXC_BAD_ADDR;
	wire [7:0] exc_code = bad_fn ? EXC_BAD_FUNC :
		frame_len != REQ_LEN ? EXC_BAD_LEN :
		fn == FN_RD_COILS ? rd_coil_exc :
		fn == FN_RD_REGS ? rd_reg_exc :
		fn == FN_WR_COIL ? wr_coil_exc : wr_reg_exc;
	wire has_exc = exc_code != EXC_NONE;
	wire go_par = !has_exc && is_par && (fn == FN_WR_REG || (fn == FN_RD_REGS && !bcast));

	// ----------------------------------------------------------------
	// Coil window and reply assembly
	// ----------------------------------------------------------------
	wire [71:0] coil_vec = {7'h00, store_to_nv, main_actual_value, drive_state_word,
		bus_speed_reference, drive_command_word};
	wire [71:0] coil_mask = ~({72{1'b1}} << value[6:0]);
	wire [71:0] coil_win = (coil_vec >> start[6:0]) & coil_mask;
	wire [6:0] qsum = value[6:0] + 7'h07;
	wire [3:0] nbytes = qsum[6:3];
	wire [7:0] coil_byte [0:8];
	wire [7:0] next_rep [0:REP_MAX-1];
	wire [3:0] next_len = has_exc ? EXC_LEN : fn == FN_RD_COILS ? EXC_LEN + nbytes :
		fn == FN_RD_REGS ? RDREG_LEN : ECHO_LEN;

	for (genvar k = 0; k < 9; k++) begin : g_coil
		assign coil_byte[k] = coil_win[8 * k +: 8];
	end

	for (genvar k = 0; k < REP_MAX; k++) begin : g_rep
		if (k == 0) begin : g_addr
			assign next_rep[k] = station_addr;
		end else if (k == 1) begin : g_fn
			assign next_rep[k] = has_exc ? (fn | EXC_FLAG) : fn;
		end else if (k == 2) begin : g_b2
			assign next_rep[k] = has_exc ? exc_code :
				fn == FN_RD_COILS ? {4'h0, nbytes} :
				fn == FN_RD_REGS ? REG_BYTES : req[2];
		end else if (k < 8) begin : g_mid
			assign next_rep[k] = fn == FN_RD_COILS ? coil_byte[k - 3] :
				fn == FN_RD_REGS ? (k == 3 ? rd_word[15:8] : rd_word[7:0]) : req[k];
		end else begin : g_tail
			assign next_rep[k] = coil_byte[k - 3];
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	wire [7:0] fifo_in;
	wire fifo_ready;
	wire sending = st == ST_SEND || st == ST_CRCL || st == ST_CRCH;
	wire push = sending && fifo_ready;
	wire [7:0] push_data = st == ST_CRCL ? crc_tx[7:0] :
		st == ST_CRCH ? crc_tx[15:8] : rep[idx];
	wire do_exec = st == ST_EXEC && !has_exc;
	wire wr_coil = do_exec && fn == FN_WR_COIL;
	wire wr_reg = do_exec && fn == FN_WR_REG && !is_par;
	assign fifo_in = push_data;

	always_comb begin
		next_st = st;
		case (st)
			ST_IDLE: begin
				if (take) begin
					next_st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_st = go_par ? ST_WAIT : bcast ? ST_IDLE : ST_SEND;
			end
			ST_WAIT: begin
				if (par_ack) begin
					next_st = bcast ? ST_IDLE : ST_SEND;
				end
			end
			ST_SEND: begin
				if (push && idx == rep_len - 4'h1) begin
					next_st = ST_CRCL;
				end
			end
			ST_CRCL: begin
				if (push) begin
					next_st = ST_CRCH;
				end
			end
			ST_CRCH: begin
				if (push) begin
					next_st = ST_IDLE;
				end
			end
			default: next_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st <= ST_IDLE;
		end else begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idx <= 4'h0;
			crc_tx <= CRC_INIT;
		end else if (st == ST_EXEC) begin
			idx <= 4'h0;
			crc_tx <= CRC_INIT;
		end else if (push && st == ST_SEND) begin
			idx <= idx + 4'h1;
			crc_tx <= mbs_crc_step(crc_tx, push_data);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rep_len <= EXC_LEN;
		end else if (st == ST_EXEC) begin
			rep_len <= next_len;
		end else if (st == ST_WAIT && par_ack && par_err) begin
			rep_len <= EXC_LEN;
		end
	end

	for (genvar k = 0; k < REP_MAX; k++) begin : g_rep_reg
		always_ff @(posedge clk) begin
			if (st == ST_EXEC) begin
				rep[k] <= next_rep[k];
			end else if (st == ST_WAIT && par_ack) begin
				if (k == 1 && par_err) begin
					rep[k] <= fn | EXC_FLAG;
				end else if (k == 2 && par_err) begin
					rep[k] <= par_err_code;
				end else if (k == 3 && !par_we) begin
					rep[k] <= par_rdata[15:8];
				end else if (k == 4 && !par_we) begin
					rep[k] <= par_rdata[7:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Drive-facing registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			drive_command_word <= RST_WORD;
			bus_speed_reference <= RST_WORD;
			store_to_nv <= 1'b0;
			parameter_array_index <= RST_WORD;
		end else if (wr_coil) begin
			if (start < COIL_REF) begin
				drive_command_word[start[3:0]] <= value == COIL_ON;
			end else if (start < COIL_STATE) begin
				bus_speed_reference[start[3:0]] <= value == COIL_ON;
			end else begin
				store_to_nv <= value == COIL_ON;
			end
		end else if (wr_reg) begin
			if (reg_no == REG_INDEX) begin
				parameter_array_index <= value;
			end else if (reg_no == REG_REF) begin
				bus_speed_reference <= value;
			end else begin
				drive_command_word <= value;
			end
		end
	end

	// Parameter store handshake; store_to_nv tells the drive where writes land
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			par_req <= 1'b0;
			par_we <= 1'b0;
			par_num <= RST_WORD;
			par_wdata <= RST_WORD;
			last_error_code <= RST_WORD;
		end else begin
			par_req <= st == ST_EXEC && go_par;
			if (st == ST_EXEC) begin
				par_we <= fn == FN_WR_REG;
				par_num <= 16'(reg_no / REGS_PER_PAR);
				par_wdata <= value;
			end
			if (st == ST_WAIT && par_ack && par_err) begin
				last_error_code <= {8'h00, par_err_code};
			end
		end
	end

	mbs_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_data(fifo_in),
		.in_valid(sending),
		.in_ready(fifo_ready),
		.out_data(tx_data),
		.out_valid(tx_valid),
		.out_ready(tx_ready)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_reply_addr: assert property (@(posedge clk) disable iff (sys_rst)
		push && st == ST_SEND && idx == 4'h0 |-> push_data == station_addr)
		else $error("reply address byte is not the station address");
	chk_bcast_quiet: assert property (@(posedge clk) disable iff (sys_rst)
		push |-> !bcast)
		else $error("reply pushed for a broadcast frame");
	chk_exc_reply: assert property (@(posedge clk) disable iff (sys_rst)
		st == ST_EXEC && has_exc && !bcast |=>
		rep[1] == ($past(fn) | EXC_FLAG) && rep[2] == $past(exc_code) && rep_len == EXC_LEN)
		else $error("exception reply malformed");
	chk_echo_fc: assert property (@(posedge clk) disable iff (sys_rst)
		st == ST_EXEC && !has_exc && !bcast |=> rep[1] == $past(fn) && st != ST_IDLE)
		else $error("function code not echoed");
	chk_crc_order: assert property (@(posedge clk) disable iff (sys_rst)
		push && st == ST_CRCL |-> push_data == crc_tx[7:0] ##1 st == ST_CRCH)
		else $error("check value byte order wrong");
	chk_crc_drop: assert property (@(posedge clk) disable iff (sys_rst)
		frame_end && !crc_ok |=> st == ST_IDLE [*2])
		else $error("frame with bad check value was served");
	chk_gap_flush: assert property (@(posedge clk) disable iff (sys_rst)
		flush |=> rx_cnt == 4'h1 && crc_rx == mbs_crc_step(CRC_INIT, $past(rx_data)))
		else $error("partial frame not flushed after gap");
	chk_store_coil: assert property (@(posedge clk) disable iff (sys_rst)
		wr_coil && start == COIL_STORE |=> store_to_nv == ($past(value) == COIL_ON))
		else $error("store selection coil not written");
	chk_addr_accept: assert property (@(posedge clk) disable iff (sys_rst)
		st == ST_IDLE ##1 st == ST_EXEC |-> $past(for_us) && $past(crc_ok))
		else $error("frame served for another station");
endmodule : mbs_rtu_slave

/* tb/mbs_master_model.sv */
// Bus master model: sends request frames and gathers reply bytes.
// Assumes byte strobes on the slave clock; drives at the falling edge.
`timescale 1ns/1ps
module mbs_master_model (
	input wire logic clk,
	output logic [7:0] rx_data,
	output logic rx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready
);
	logic [7:0] rep[$];
	bit slow;
	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
		slow = 1'b0;
	end
	// ----------------------------------------------------------------
	// Check value over a byte list
	// ----------------------------------------------------------------
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			for (int k = 0; k < 8; k++) begin
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
			end
		end
		return c;
	endfunction : crc16
	// ----------------------------------------------------------------
	// Request and reply
	// ----------------------------------------------------------------
	// Mode 0 appends a good check value, 1 a corrupted one, 2 none
	task automatic send(input logic [7:0] q[$], input int mode);
		logic [15:0] c;
		c = crc16(q);
		if (mode != 2) begin
			q.push_back(c[7:0] ^ ((mode == 1) ? 8'h01 : 8'h00));
			q.push_back(c[15:8]);
		end
		// Address, function and data bytes come from the caller
		foreach (q[i]) begin
			@(negedge clk);
			rx_data = q[i];
			rx_valid = 1'b1;
			@(negedge clk);
			rx_valid = 1'b0;
			// Idle data line never repeats the last byte
			rx_data = ~q[i];
			repeat (2) @(negedge clk);
		end
	endtask : send
	// Ends after 80 quiet cycles, well past the frame-end silence
	task automatic recv();
		int idle;
		rep.delete();
		idle = 0;
		while (idle < 80) begin
			@(negedge clk);
			tx_ready = slow ? ~tx_ready : 1'b1;
			if (tx_valid && tx_ready) begin
				rep.push_back(tx_data);
				idle = 0;
			end else begin
				idle++;
			end
		end
		@(negedge clk);
		tx_ready = 1'b0;
	endtask : recv
endmodule : mbs_master_model

/* tb/mbs_rtu_slave_test.sv */
// Testbench for the RTU slave: frames from the master model, replies checked.
// Assumes short silence parameters and a parameter store answered here.
`timescale 1ns/1ps
module mbs_rtu_slave_test;
	import mbs_pkg::*;
	logic clk;
	logic sys_rst;
	logic [7:0] station_addr;
	logic [7:0] rx_data;
	logic rx_valid;
	logic [7:0] tx_data;
	logic tx_valid;
	logic tx_ready;
	logic [15:0] drive_state_word;
	logic [15:0] main_actual_value;
	logic [15:0] drive_command_word;
	logic [15:0] bus_speed_reference;
	logic store_to_nv;
	logic [15:0] parameter_array_index;
	logic par_req;
	logic par_we;
	logic [15:0] par_num;
	logic [15:0] par_wdata;
	logic par_ack;
	logic [15:0] par_rdata;
	logic par_err;
	logic [7:0] par_err_code;
	logic [7:0] no_reply[$];
	int err_count;
	int tests_run;
	int par_wait;
	logic [7:0] f[$];
	mbs_rtu_slave #(.GAP_FLUSH_CLKS(15), .GAP_END_CLKS(35)) i_mbs_rtu_slave (
		.clk(clk), .sys_rst(sys_rst), .station_addr(station_addr), .rx_data(rx_data),
		.rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.drive_state_word(drive_state_word), .main_actual_value(main_actual_value),
		.drive_command_word(drive_command_word), .bus_speed_reference(bus_speed_reference),
		.store_to_nv(store_to_nv), .parameter_array_index(parameter_array_index),
		.par_req(par_req), .par_we(par_we), .par_num(par_num), .par_wdata(par_wdata),
		.par_ack(par_ack), .par_rdata(par_rdata), .par_err(par_err), .par_err_code(par_err_code)
	);
	mbs_master_model i_master (
		.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready)
	);
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Parameter store answers three cycles after each request; writes to 200 fail
	always @(negedge clk) begin
		par_ack = 1'b0;
		par_err = 1'b0;
		if (par_req) begin
			par_wait = 3;
		end else if (par_wait > 0) begin
			par_wait--;
			par_ack = (par_wait == 0);
			par_err = par_ack && par_we && par_num == 16'h00c8;
		end
	end
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic txn(input logic [7:0] q[$], input logic [7:0] e[$], input int mode);
		logic [15:0] c;
		i_master.send(q, mode);
		i_master.recv();
		if (e.size() > 0) begin
			c = i_master.crc16(e);
			e.push_back(c[7:0]);
			e.push_back(c[15:8]);
		end
		check("reply_len", i_master.rep.size(), e.size());
		foreach (e[i]) check("reply_byte", i_master.rep[i], e[i]);
	endtask : txn
	task automatic stop_test();
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#300000;
		err_count++;
		stop_test();
	end
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		station_addr = 8'h01;
		drive_state_word = 16'ha5c3;
		main_actual_value = 16'h5a3c;
		par_ack = 1'b0;
		par_wait = 0;
		err_count = 0;
		tests_run = 0;
		repeat (10) @(negedge clk);
		sys_rst = 1'b0;
		par_rdata = 16'hbeef;
		par_err_code = 8'h12;
		for (int k = 0; k < 16; k++) begin
			f = '{8'h01, 8'h05, 8'h00, 8'(k), 8'hff, 8'h00};
			txn(f, f, 0);
			check("command", drive_command_word, 16'hffff >> (15 - k));
		end
		f = '{8'h01, 8'h06, 8'hc3, 8'h59, 8'h12, 8'h34};
		txn(f, f, 0);
		f = '{8'h01, 8'h05, 8'h00, 8'h10, 8'hff, 8'h00};
		txn(f, f, 0);
		check("reference", bus_speed_reference, 16'h1235);
		i_master.slow = 1'b1;
		f = '{8'h01, 8'h01, 8'h00, 8'h20, 8'h00, 8'h10};
		txn(f, '{8'h01, 8'h01, 8'h02, 8'hc3, 8'ha5}, 0);
		f = '{8'h01, 8'h01, 8'h00, 8'h30, 8'h00, 8'h10};
		txn(f, '{8'h01, 8'h01, 8'h02, 8'h3c, 8'h5a}, 0);
		i_master.slow = 1'b0;
		f = '{8'h01, 8'h06, 8'h00, 8'h08, 8'h00, 8'h07};
		txn(f, f, 0);
		check("array_index", parameter_array_index, 16'h0007);
		f = '{8'h01, 8'h03, 8'h00, 8'h08, 8'h00, 8'h01};
		txn(f, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h07}, 0);
		f = '{8'h01, 8'h05, 8'h00, 8'h40, 8'hff, 8'h00};
		txn(f, f, 0);
		check("store_nv", store_to_nv, 1'b1);
		f = '{8'h01, 8'h2b, 8'h00, 8'h00, 8'h00, 8'h00};
		txn(f, '{8'h01, 8'hab, 8'h43}, 0);
		f = '{8'h01, 8'h06, 8'hc4, 8'h17, 8'h00, 8'h01};
		txn(f, '{8'h01, 8'h86, 8'h0b}, 0);
		f = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
		txn(f, '{8'h01, 8'h81, 8'h42}, 0);
		f = '{8'h01, 8'h05, 8'h00, 8'h20, 8'hff, 8'h00};
		txn(f, '{8'h01, 8'h85, 8'h0b}, 0);
		f = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
		txn(f, '{8'h01, 8'h83, 8'h40}, 0);
		f = '{8'h01, 8'h03, 8'h00, 8'h08, 8'h00};
		txn(f, '{8'h01, 8'h83, 8'h41}, 0);
		f = '{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
		txn(f, no_reply, 1);
		check("command", drive_command_word, 16'hffff);
		f = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
		txn(f, no_reply, 0);
		check("command", drive_command_word, 16'hfffe);
		f = '{8'h02, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00};
		txn(f, no_reply, 0);
		check("command", drive_command_word, 16'hfffe);
		f = '{8'h01, 8'h06, 8'h03, 8'he7, 8'h00, 8'h2a};
		txn(f, f, 0);
		check("par_num", par_num, 16'h0064);
		check("par_write", {par_we, par_wdata}, 17'h1002a);
		f = '{8'h01, 8'h03, 8'h03, 8'he7, 8'h00, 8'h01};
		txn(f, '{8'h01, 8'h03, 8'h02, 8'hbe, 8'hef}, 0);
		check("par_read", par_we, 1'b0);
		f = '{8'h01, 8'h06, 8'h07, 8'hcf, 8'h00, 8'h05};
		txn(f, '{8'h01, 8'h86, 8'h12}, 0);
		check("par_num", par_num, 16'h00c8);
		f = '{8'h01, 8'h03, 8'h00, 8'h06, 8'h00, 8'h01};
		txn(f, '{8'h01, 8'h03, 8'h02, 8'h00, 8'h12}, 0);
		i_master.send('{8'h01, 8'h05}, 2);
		repeat (20) @(negedge clk);
		f = '{8'h01, 8'h05, 8'h00, 8'h00, 8'hff, 8'h00};
		txn(f, f, 0);
		check("command", drive_command_word, 16'hffff);
		station_addr = 8'hf7;
		f = '{8'hf7, 8'h03, 8'h00, 8'h08, 8'h00, 8'h01};
		txn(f, '{8'hf7, 8'h03, 8'h02, 8'h00, 8'h07}, 0);
		stop_test();
	end
endmodule : mbs_rtu_slave_test
